// ---- core/tws_guard_timer.sv ----
// Down-counting guard interval timer loaded with a count of 20 MHz periods.
// Assumes a synchronous reset copy and the 10 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module tws_guard_timer
   import tws_pkg::*;
(
   // Clock and reset.
   input  wire logic        clk,
   input  wire logic        rstSync_b,
   // Load and state.
   input  wire logic        load,
   input  wire logic [15:0] loadVal,
   output logic             active
);
   logic [15:0] cnt_q;

   // Each clock consumes two 20 MHz periods, so 2000 lasts 1000 clocks.
   always_ff @(posedge clk or negedge rstSync_b) begin
      if (!rstSync_b) begin
         cnt_q <= 16'h0000;
      end else if (load) begin
         cnt_q <= loadVal;
      end else if (cnt_q > GUARD_STEP) begin
         cnt_q <= cnt_q - GUARD_STEP;
      end else begin
         cnt_q <= 16'h0000;
      end
   end

   assign active = (cnt_q != 16'h0000);

   a_guard_step_down: assert property (@(posedge clk) disable iff (!rstSync_b)
      active && !load |=> cnt_q == (($past(cnt_q) > GUARD_STEP) ? $past(cnt_q) - GUARD_STEP : 16'h0000))
      else $error("Guard count did not step by two periods.");
endmodule : tws_guard_timer
`default_nettype wire

// ---- core/tws_lut_control.sv ----
// Gear regulation, guard timers and shaping-table search for the transmitter.
// Assumes APB from software, a byte-wide table store and event pulses on clk.
`timescale 1ns/1ps
`default_nettype none
module tws_lut_control
   import tws_pkg::*;
(
   // Clock and reset.
   input  wire logic                clk,
   input  wire logic                rst_b,
   // APB slave.
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [31:0]         paddr,
   input  wire logic [31:0]         pwdata,
   output logic                     pready,
   output logic                     pslverr,
   output logic [31:0]              prdata,
   // Receive path events and gain measurement.
   input  wire tws_pkg::tws_evt_s   evt,
   input  wire logic                measStrobe,
   input  wire logic [7:0]          gainValue,
   // Table store byte port.
   output tws_pkg::tws_nvm_req_s    nvm,
   input  wire logic                nvmValid,
   input  wire logic [7:0]          nvmData,
   // Analogue side.
   output tws_pkg::tws_shape_s      txShape,
   output logic [3:0]               gear,
   output logic                     regBlocked
);
   import tws_pkg::*;

   typedef enum logic [1:0] {S_IDLE, S_FETCH, S_CHECK} tws_state_e;

   logic            rstMeta_b;
   logic            rstSync_b;
   logic [15:0]     fastGuard_q;
   logic [15:0]     frameGuard_q;
   logic [15:0]     fieldGuard_q;
   logic [7:0]      entryCnt_q;
   logic            regEnable_q;
   logic            fieldOn_q;
   logic [7:0]      thrHi_q;
   logic [7:0]      thrLo_q;
   logic [3:0]      maxGear_q;
   logic [3:0]      protocol_q;
   tws_shape_s      shape_q;
   tws_shape_s      shapeAdj;
   logic [3:0]      gear_q;
   logic            waitRx_q;
   logic            pending_q;
   tws_state_e      state_q;
   logic [4:0]      idx_q;
   logic [1:0]      byteCnt_q;
   logic [23:0]     addr_q;
   logic [31:0]     word_q;
   logic [31:0]     rdData_q;
   logic            hit_q;
   logic            fastAct;
   logic            frameAct;
   logic            fieldAct;
   logic            wrEn;
   logic            gearUp;
   logic            gearDown;
   logic            gearChange;
   logic            protLoad;
   logic            shapeWr;
   logic            match;
   logic            pastGear;
   logic            lastEntry;
   logic [4:0]      limit;
   logic [31:0]     rdMux;
   logic            rdHit;

   // Reset is asserted at once but released through two flops.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rstMeta_b <= 1'b0;
         rstSync_b <= 1'b0;
      end else begin
         rstMeta_b <= 1'b1;
         rstSync_b <= rstMeta_b;
      end
   end

   // Writes land at the access edge; reads are sampled in setup.
   assign wrEn     = psel && penable && pwrite;
   assign protLoad = wrEn && (paddr == tws_byte_addr(IDX_PROT_LOAD));
   assign shapeWr  = wrEn && (paddr == tws_byte_addr(IDX_SHAPE));

   // Read decode; unmapped addresses answer with an error and zero data.
   always_comb begin
      rdHit = 1'b1;
      rdMux = 32'h0000_0000;
      unique case (paddr)
         tws_byte_addr(IDX_FAST_GUARD): rdMux = {16'h0000, fastGuard_q};
         tws_byte_addr(IDX_FRAME_GRD):  rdMux = {16'h0000, frameGuard_q};
         tws_byte_addr(IDX_FIELD_GRD):  rdMux = {16'h0000, fieldGuard_q};
         tws_byte_addr(IDX_ENTRY_CNT):  rdMux = {24'h000000, entryCnt_q};
         tws_byte_addr(IDX_CTRL):       rdMux = {30'h0, fieldOn_q, regEnable_q};
         tws_byte_addr(IDX_GEAR_CFG):   rdMux = {12'h000, maxGear_q, thrHi_q, thrLo_q};
         tws_byte_addr(IDX_PROT_LOAD):  rdMux = {28'h0000000, protocol_q};
         tws_byte_addr(IDX_SHAPE):      rdMux = {20'h00000, shape_q};
         tws_byte_addr(IDX_STATUS):     rdMux = {18'h00000, pending_q, state_q != S_IDLE,
                                                 waitRx_q, fieldAct, frameAct, fastAct,
                                                 protocol_q, gear_q};
         default:                       rdHit = 1'b0;
      endcase
   end

   // Read data and decode hit are held for the access phase.
   always_ff @(posedge clk or negedge rstSync_b) begin
      if (!rstSync_b) begin
         rdData_q <= 32'h0000_0000;
         hit_q    <= 1'b0;
      end else if (psel && !penable) begin
         rdData_q <= rdMux;
         hit_q    <= rdHit;
      end
   end

   assign pready  = penable;
   assign pslverr = psel && penable && !hit_q;
   assign prdata  = rdData_q;

   // Software-written configuration registers.
   always_ff @(posedge clk or negedge rstSync_b) begin
      if (!rstSync_b) begin
         fastGuard_q  <= RST_GUARD;
         frameGuard_q <= RST_GUARD;
         fieldGuard_q <= RST_GUARD;
         entryCnt_q   <= RST_ENTRY_CNT;
         regEnable_q  <= 1'b0;
         fieldOn_q    <= 1'b0;
         thrHi_q      <= RST_THR_HI;
         thrLo_q      <= RST_THR_LO;
         maxGear_q    <= MAX_GEARS;
         protocol_q   <= 4'h0;
      end else if (wrEn) begin
         unique case (paddr)
            tws_byte_addr(IDX_FAST_GUARD): fastGuard_q  <= pwdata[15:0];
            tws_byte_addr(IDX_FRAME_GRD):  frameGuard_q <= pwdata[15:0];
            tws_byte_addr(IDX_FIELD_GRD):  fieldGuard_q <= pwdata[15:0];
            tws_byte_addr(IDX_ENTRY_CNT):  entryCnt_q   <= pwdata[7:0];
            tws_byte_addr(IDX_CTRL): begin
               regEnable_q <= pwdata[0];
               fieldOn_q   <= pwdata[1];
            end
            tws_byte_addr(IDX_GEAR_CFG): begin
               thrLo_q   <= pwdata[THR_LO_LSB +: 8];
               thrHi_q   <= pwdata[THR_HI_LSB +: 8];
               maxGear_q <= pwdata[MAXG_LSB +: 4];
            end
            tws_byte_addr(IDX_PROT_LOAD):  protocol_q <= pwdata[3:0];
            default: ;
         endcase
      end
   end

   // Regulation may only move the gear outside every guard interval.
   assign regBlocked = fastAct || frameAct || fieldAct || waitRx_q;
   assign gearUp     = measStrobe && regEnable_q && !regBlocked &&
                       (gainValue > thrHi_q) && (gear_q < maxGear_q);
   assign gearDown   = measStrobe && regEnable_q && !regBlocked &&
                       (gainValue < thrLo_q) && (gear_q > GEAR_MIN);
   assign gearChange = gearUp || gearDown;

   // Active gear, one step per measurement.
   always_ff @(posedge clk or negedge rstSync_b) begin
      if (!rstSync_b) begin
         gear_q <= RST_GEAR;
      end else if (gearUp) begin
         gear_q <= gear_q + 4'h1;
      end else if (gearDown) begin
         gear_q <= gear_q - 4'h1;
      end
   end

   // Frame start holds regulation off until reception begins; a new frame start wins.
   always_ff @(posedge clk or negedge rstSync_b) begin
      if (!rstSync_b) begin
         waitRx_q <= 1'b0;
      end else if (evt.sofDetect) begin
         waitRx_q <= 1'b1;
      end else if (evt.rxStart) begin
         waitRx_q <= 1'b0;
      end
   end

   // Field-on gear switches use their own guard instead of the fast one.
   tws_guard_timer u_fastGuard (
      .clk       (clk),
      .rstSync_b (rstSync_b),
      .load      (evt.rxEnd || evt.txEnd || (gearChange && !fieldOn_q)),
      .loadVal   (fastGuard_q),
      .active    (fastAct)
   );

   tws_guard_timer u_frameGuard (
      .clk       (clk),
      .rstSync_b (rstSync_b),
      .load      (evt.sofDetect),
      .loadVal   (frameGuard_q),
      .active    (frameAct)
   );

   tws_guard_timer u_fieldGuard (
      .clk       (clk),
      .rstSync_b (rstSync_b),
      .load      (gearChange && fieldOn_q),
      .loadVal   (fieldGuard_q),
      .active    (fieldAct)
   );

   // A trigger during a search queues one rerun; a new trigger beats the start.
   always_ff @(posedge clk or negedge rstSync_b) begin
      if (!rstSync_b) begin
         pending_q <= 1'b0;
      end else if (gearChange || protLoad) begin
         pending_q <= 1'b1;
      end else if (state_q == S_IDLE) begin
         pending_q <= 1'b0;
      end
   end

   // Entry decode; the table capacity caps whatever count software set.
   assign limit     = (entryCnt_q > {3'h0, TABLE_WORDS}) ? TABLE_WORDS : entryCnt_q[4:0];
   assign match     = (word_q[31:RFU_LSB] == 3'h0) &&
                      word_q[MASK_LSB + protocol_q] &&
                      (word_q[GEAR_LSB +: 4] == gear_q);
   assign pastGear  = word_q[GEAR_LSB +: 4] > gear_q;
   assign lastEntry = (idx_q + 5'h01 >= limit) || pastGear;

   // Search walk: four bytes per entry, then one decision cycle.
   always_ff @(posedge clk or negedge rstSync_b) begin
      if (!rstSync_b) begin
         state_q   <= S_IDLE;
         idx_q     <= 5'h00;
         byteCnt_q <= 2'h0;
         addr_q    <= TABLE_BASE;
         word_q    <= 32'h0000_0000;
      end else begin
         unique case (state_q)
            S_IDLE: begin
               if (pending_q && limit != 5'h00) begin
                  state_q   <= S_FETCH;
                  idx_q     <= 5'h00;
                  byteCnt_q <= 2'h0;
                  addr_q    <= TABLE_BASE;
               end
            end
            S_FETCH: begin
               if (nvmValid) begin
                  word_q    <= {nvmData, word_q[31:8]};
                  addr_q    <= addr_q + 24'h000001;
                  byteCnt_q <= byteCnt_q + 2'h1;
                  if (byteCnt_q == 2'h3) begin
                     state_q <= S_CHECK;
                  end
               end
            end
            S_CHECK: begin
               if (lastEntry) begin
                  state_q <= S_IDLE;
               end else begin
                  state_q <= S_FETCH;
                  idx_q   <= idx_q + 5'h01;
               end
            end
         endcase
      end
   end

   assign nvm.req  = (state_q == S_FETCH);
   assign nvm.addr = addr_q;

   // Each field moves relative to its present value.
   tws_sat_adjust u_adjRes (
      .field  (shape_q.residual),
      .adj    (word_q[RES_LSB +: 4]),
      .result (shapeAdj.residual)
   );

   tws_sat_adjust u_adjRise (
      .field  (shape_q.rising),
      .adj    (word_q[RISE_LSB +: 4]),
      .result (shapeAdj.rising)
   );

   tws_sat_adjust u_adjFall (
      .field  (shape_q.falling),
      .adj    (word_q[FALL_LSB +: 4]),
      .result (shapeAdj.falling)
   );

   // Software sets the base at protocol load; matches then stack on it.
   always_ff @(posedge clk or negedge rstSync_b) begin
      if (!rstSync_b) begin
         shape_q <= '0;
      end else if (shapeWr) begin
         shape_q <= pwdata[11:0];
      end else if (state_q == S_CHECK && match) begin
         shape_q <= shapeAdj;
      end
   end

   assign txShape = shape_q;
   assign gear    = gear_q;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstSync_b);

   a_gear_moves_only: assert property (
      gear_q != $past(gear_q) |-> $past(measStrobe && regEnable_q && !regBlocked))
      else $error("Gear moved without an allowed measurement.");
   a_gear_in_range: assert property (
      gear_q >= GEAR_MIN && gear_q <= MAX_GEARS)
      else $error("Gear left the legal range.");
   a_fast_guard_start: assert property (
      (evt.txEnd && fastGuard_q > GUARD_STEP) |=> fastAct && regBlocked)
      else $error("Transmit end did not start the fast guard.");
   a_wait_for_rx: assert property (
      evt.sofDetect |=> waitRx_q && regBlocked)
      else $error("Frame start did not block regulation.");
   a_field_guard_use: assert property (
      (gearChange && fieldOn_q && fieldGuard_q > GUARD_STEP) |=> fieldAct)
      else $error("Field-on gear change did not start its guard.");
   a_search_follows: assert property (
      (protLoad && state_q == S_IDLE && entryCnt_q != 8'h00) |-> ##[1:2] state_q == S_FETCH)
      else $error("Protocol load did not start a search.");
   a_entry_bounded: assert property (
      state_q == S_CHECK |-> idx_q < limit)
      else $error("Search passed the entry count.");
   a_bytes_in_order: assert property (
      (nvm.req && nvmValid) |=> nvm.addr == $past(nvm.addr) + 24'h000001)
      else $error("Table bytes not fetched in sequence.");
   a_skip_keeps_shape: assert property (
      (state_q == S_CHECK && !match && !shapeWr) |=> $stable(shape_q))
      else $error("Non-matching entry changed the shaping.");

   c_entry_applied:  cover property (state_q == S_CHECK && match);
   c_gear_up_search: cover property (gearUp ##[1:3] state_q == S_FETCH);
   c_rerun_queued:   cover property (state_q != S_IDLE && pending_q);
   c_frame_then_rx:  cover property (evt.sofDetect ##[1:100] evt.rxStart);
endmodule : tws_lut_control
`default_nettype wire

// ---- core/tws_pkg.sv ----
// Constants, register map and carrier types for the transmitter wave-shaping block.
// Assumes a 10 MHz system clock and one APB slave per block instance.
// Function
// - Gear steps up or down when gain leaves threshold window; at most 15 gears.
// - Fast guard starts after receive end, transmit end and each gear change made with field-on clear.
// - Frame-detect guard starts on frame start; regulation waits until reception begins.
// - Guard settings count 20 MHz periods; field-on guard follows gear change.
// - Only the programmed entry count of table entries is examined.
// - Bits 28 to 16 mask protocols; entry applies when active protocol bit set.
// - Mask bit order: mode3, vicinity 100/10, F 424/212, B and A rates.
// - Bits 3 to 0 give the gear; entry used only for current gear.
// - Residual, rising and falling adjustments are sign plus 3-bit magnitude.
// - Each gear change starts a table search.
// - Each protocol load starts a table search.
// - Matching entries add to or subtract from the shaping fields.
// - Adjustments are relative to the current shaping value set by protocol load.
// - Rising gears accumulate successive adjustments.
// - Table fetched from consecutive memory bytes, least significant byte first.
// - Shaping follows the active gear automatically.
package tws_pkg;

   // Timing: guard counts are in 20 MHz periods, the clock runs at 10 MHz.
   localparam int          CLK_PERIOD_NS  = 100;
   localparam int          GUARD_TICK_NS  = 50;
   localparam logic [15:0] GUARD_STEP     = 16'(CLK_PERIOD_NS / GUARD_TICK_NS);

   // Register indexes; the byte address is four times the index.
   localparam logic [23:0] IDX_FAST_GUARD = 24'h20132E;
   localparam logic [23:0] IDX_FRAME_GRD  = 24'h201330;
   localparam logic [23:0] IDX_FIELD_GRD  = 24'h201332;
   localparam logic [23:0] IDX_ENTRY_CNT  = 24'h2013A8;
   localparam logic [23:0] IDX_CTRL       = 24'h201400;
   localparam logic [23:0] IDX_GEAR_CFG   = 24'h201401;
   localparam logic [23:0] IDX_PROT_LOAD  = 24'h201402;
   localparam logic [23:0] IDX_SHAPE      = 24'h201403;
   localparam logic [23:0] IDX_STATUS     = 24'h201404;

   // Reset values.
   localparam logic [15:0] RST_GUARD      = 16'h07D0;
   localparam logic [7:0]  RST_ENTRY_CNT  = 8'h00;
   localparam logic [7:0]  RST_THR_HI     = 8'hFF;
   localparam logic [7:0]  RST_THR_LO     = 8'h00;
   localparam logic [3:0]  RST_GEAR       = 4'h1;

   // Gear and table layout.
   localparam logic [3:0]  GEAR_MIN       = 4'h1;
   localparam logic [3:0]  MAX_GEARS      = 4'hF;
   localparam logic [23:0] TABLE_BASE     = 24'h201368;
   localparam logic [4:0]  TABLE_WORDS    = 5'h10;
   localparam int          GEAR_LSB       = 0;
   localparam int          FALL_LSB       = 4;
   localparam int          RISE_LSB       = 8;
   localparam int          RES_LSB        = 12;
   localparam int          MASK_LSB       = 16;
   localparam int          RFU_LSB        = 29;
   localparam int          THR_LO_LSB     = 0;
   localparam int          THR_HI_LSB     = 8;
   localparam int          MAXG_LSB       = 16;

   // Analogue shaping fields, each unsigned.
   typedef struct packed {
      logic [3:0] residual;
      logic [3:0] rising;
      logic [3:0] falling;
   } tws_shape_s;

   // Byte read request towards the nonvolatile store.
   typedef struct packed {
      logic        req;
      logic [23:0] addr;
   } tws_nvm_req_s;

   // Receive path events, one-cycle pulses.
   typedef struct packed {
      logic rxEnd;
      logic txEnd;
      logic sofDetect;
      logic rxStart;
   } tws_evt_s;

   function automatic logic [31:0] tws_byte_addr(input logic [23:0] idx);
      return {6'h00, idx, 2'h0};
   endfunction : tws_byte_addr

endpackage : tws_pkg

// ---- core/tws_sat_adjust.sv ----
// Applies one sign-magnitude adjustment to an unsigned 4-bit shaping field.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
`default_nettype none
module tws_sat_adjust (
   // Field and adjustment.
   input  wire logic [3:0] field,
   input  wire logic [3:0] adj,
   output logic [3:0]      result
);
   logic [4:0] wide;
   logic [4:0] mag;

   // Clip rather than wrap, so a large step never flips to the far end.
   always_comb begin
      mag  = {2'b00, adj[2:0]};
      wide = 5'h00;
      if (adj[3]) begin
         wide   = {1'b0, field} - mag;
         result = ({1'b0, field} < mag) ? 4'h0 : wide[3:0];
      end else begin
         wide   = {1'b0, field} + mag;
         result = wide[4] ? 4'hF : wide[3:0];
      end
   end
endmodule : tws_sat_adjust
`default_nettype wire

// ---- dv/tws_nvm_model.sv ----
// Behavioural byte-wide table store that answers the block's fetch port.
// Assumes the block holds req and addr steady until each byte is accepted.
`timescale 1ns/1ps
`default_nettype none
module tws_nvm_model
   import tws_pkg::*;
(
   // Clock and answer speed.
   input  wire logic                  clk,
   input  wire logic                  slow,
   // Fetch port.
   input  wire tws_pkg::tws_nvm_req_s nvm,
   output logic                       nvmValid,
   output logic [7:0]                 nvmData
);
   import tws_pkg::*;
   logic [7:0]  mem [0:63];
   logic [7:0]  lastByte = 8'h00;
   logic        tick     = 1'b0;
   logic [23:0] ofs;

   // A slow store answers only every other cycle, like a busy array.
   assign ofs      = nvm.addr - TABLE_BASE;
   assign nvmValid = nvm.req && (!slow || tick);
   // Idle data is the inverse of the last byte, so a stale value never passes.
   assign nvmData  = nvmValid ? mem[ofs[5:0]] : ~lastByte;

   // Track the answer phase and the last byte handed over.
   always @(posedge clk) begin
      tick <= ~tick;
      if (nvmValid) begin
         lastByte <= nvmData;
      end
   end
endmodule : tws_nvm_model
`default_nettype wire

// ---- dv/tx_wave_shaping_lut_control_test.sv ----
// Self-checking bench for the wave-shaping block: APB master, events, table store.
// Assumes the design package and the table store model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tx_wave_shaping_lut_control_test;
   import tws_pkg::*;
   logic         clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [31:0]  paddr = 32'h0, pwdata = 32'h0, prdata, rdat;
   logic         pready, pslverr, rerr, nvmValid, regBlocked;
   logic         measStrobe = 1'b0, slow = 1'b0;
   logic [7:0]   gainValue = 8'h00, nvmData;
   logic [3:0]   gear;
   tws_evt_s     evt = '0;
   tws_nvm_req_s nvm;
   tws_shape_s   txShape;
   int           n_mismatch = 0, cmp_count = 0, cyc = 0;

   tws_lut_control dut_u (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
      .prdata(prdata), .evt(evt), .measStrobe(measStrobe), .gainValue(gainValue), .nvm(nvm),
      .nvmValid(nvmValid), .nvmData(nvmData), .txShape(txShape), .gear(gear),
      .regBlocked(regBlocked));
   tws_nvm_model nvm_u (.clk(clk), .slow(slow), .nvm(nvm), .nvmValid(nvmValid),
      .nvmData(nvmData));

   // 10 MHz clock; a hang is cut off well beyond the few hundred cycles needed.
   always #50 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc > 20000) begin
         n_mismatch++;
         conclude();
      end
   end

   task conclude();
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : conclude

   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("unexpected %s: expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // One APB transfer; request held until pready is seen at a rising edge.
   task apb(input logic w, input logic [23:0] i, input logic [31:0] d);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= {6'h00, i, 2'h0};
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb

   task pulse(input tws_evt_s e);
      evt <= e;
      @(posedge clk);
      evt <= '0;
   endtask : pulse

   // Table words go in low byte first, as the store keeps them.
   task putWord(input int k, input logic [31:0] w);
      for (int b = 0; b < 4; b++) nvm_u.mem[4*k+b] = w[8*b +: 8];
   endtask : putWord

   // Poll status until neither busy nor pending, bounded.
   task waitIdle();
      int n;
      n = 0;
      do begin
         apb(1'b0, IDX_STATUS, 32'h0);
         n++;
      end while (rdat[13:12] !== 2'h0 && n < 100);
      chk("search idle", 32'h0, {30'h0, rdat[13:12]});
   endtask : waitIdle

   task testReset();
      chk("gear", 32'h1, {28'h0, gear});
      chk("txShape", 32'h0, {20'h0, txShape});
      apb(1'b0, IDX_FAST_GUARD, 32'h0);
      chk("fast guard", {16'h0, RST_GUARD}, rdat);
      apb(1'b0, IDX_FIELD_GRD, 32'h0);
      chk("field guard", {16'h0, RST_GUARD}, rdat);
      apb(1'b0, IDX_ENTRY_CNT, 32'h0);
      chk("entry count", 32'h0, rdat);
      apb(1'b0, 24'h201405, 32'h0);
      chk("unmapped error", 32'h1, {31'h0, rerr});
      $display("test reset done");
   endtask : testReset

   // A count of 20 ticks gives 10 cycles; frame start holds regulation until reception starts.
   task testGuards();
      apb(1'b1, IDX_FAST_GUARD, 32'h14);
      apb(1'b1, IDX_FRAME_GRD, 32'h4);
      pulse(4'h4);
      @(posedge clk);
      chk("blocked early", 32'h1, {31'h0, regBlocked});
      repeat (7) @(posedge clk);
      chk("blocked late", 32'h1, {31'h0, regBlocked});
      repeat (4) @(posedge clk);
      chk("guard over", 32'h0, {31'h0, regBlocked});
      pulse(4'h8);
      @(posedge clk);
      chk("rx end guard", 32'h1, {31'h0, regBlocked});
      pulse(4'h2);
      repeat (10) @(posedge clk);
      chk("wait for rx", 32'h1, {31'h0, regBlocked});
      pulse(4'h1);
      repeat (3) @(posedge clk);
      chk("rx begun", 32'h0, {31'h0, regBlocked});
      $display("test guards done");
   endtask : testGuards

   // Base 5/1/4; entries are sign plus magnitude; the a106 entry saturates rising and falling at 0.
   task testLoad();
      putWord(0, 32'h00013AF1);
      putWord(1, 32'h00041011);
      putWord(2, 32'h00059702);
      apb(1'b1, IDX_ENTRY_CNT, 32'h1);
      apb(1'b1, IDX_SHAPE, 32'h514);
      apb(1'b1, IDX_PROT_LOAD, 32'h2);
      waitIdle();
      chk("shape count1", 32'h514, {20'h0, txShape});
      apb(1'b1, IDX_ENTRY_CNT, 32'h3);
      apb(1'b1, IDX_PROT_LOAD, 32'h0);
      waitIdle();
      chk("shape a106", 32'h800, {20'h0, txShape});
      apb(1'b1, IDX_SHAPE, 32'h514);
      apb(1'b1, IDX_PROT_LOAD, 32'h2);
      waitIdle();
      chk("shape a424", 32'h615, {20'h0, txShape});
      $display("test load done");
   endtask : testLoad

   // Gain above the high threshold steps the gear and adds the gear-2 entry; a low gain
   // with the field-on instruction steps back under the field guard and reapplies gear 1.
   task testGear();
      slow <= 1'b1;
      apb(1'b1, IDX_CTRL, 32'h1);
      apb(1'b1, IDX_GEAR_CFG, 32'h000F1000);
      gainValue  <= 8'h20;
      measStrobe <= 1'b1;
      @(posedge clk);
      measStrobe <= 1'b0;
      @(posedge clk);
      chk("gear up", 32'h2, {28'h0, gear});
      chk("gear guard", 32'h1, {31'h0, regBlocked});
      waitIdle();
      chk("shape gear2", 32'h585, {20'h0, txShape});
      apb(1'b1, IDX_FIELD_GRD, 32'h6);
      apb(1'b1, IDX_CTRL, 32'h3);
      apb(1'b1, IDX_GEAR_CFG, 32'h000F1010);
      gainValue  <= 8'h08;
      measStrobe <= 1'b1;
      @(posedge clk);
      measStrobe <= 1'b0;
      @(posedge clk);
      chk("gear down", 32'h1, {28'h0, gear});
      apb(1'b0, IDX_STATUS, 32'h0);
      chk("field guard on", 32'h1, {31'h0, rdat[10]});
      chk("fast guard off", 32'h0, {31'h0, rdat[8]});
      waitIdle();
      chk("shape gear1", 32'h686, {20'h0, txShape});
      $display("test gear done");
   endtask : testGear

   initial begin
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk);
      testReset();
      testGuards();
      testLoad();
      testGear();
      conclude();
   end
endmodule : tx_wave_shaping_lut_control_test
`default_nettype wire
